/* hw/gen_ctrl_map.vh */
// Register map, field positions and timing constants of the general control bank
`ifndef GEN_CTRL_MAP_VH
`define GEN_CTRL_MAP_VH

// Register offsets (7-bit address space)
`define ADDR_CALIB_CODE_HIGH 7'h6C
`define ADDR_CALIB_CODE_LOW 7'h6D
`define ADDR_DEVICE_STATUS 7'h6E
`define ADDR_BIAS_LEVEL_READOUT 7'h6F
`define ADDR_DIVIDER_INIT_CONTROL 7'h70
`define ADDR_DELAY_CAL_CONTROL 7'h71
`define ADDR_BIAS_CAL_CONTROL 7'h72
`define ADDR_ALIGN_AND_SPI_CONTROL 7'h73

// Field positions
`define TRIGGER_BIT 7
`define STATUS_ALIGN_BIT 5
`define STATUS_READY_BIT 1
`define EDGE_SELECT_BIT 0
`define CALIB_HIGH_MSB 14
`define CALIB_HIGH_LSB 8
`define CALIB_LOW_MSB 7

// Field widths and reset values
`define CALIB_CODE_WIDTH 15
`define BIAS_CODE_WIDTH 6
`define EDGE_SELECT_RESET 1'h0
`define ALIGN_START_RESET 1'h0

// SPI frame: read flag, 7 address bits, 8 data bits
`define FRAME_BITS 5'h10
`define HEADER_LAST_BIT 5'h07
`define FRAME_LAST_BIT 5'h0F
`define READ_FLAG_BIT 7

// Timing, in nanoseconds, at the system clock rate in MHz
`define SYS_CLK_MHZ 250
`define STARTUP_TIME_NS 1000
`define SAR_SETTLE_NS 40
`define ALIGN_TIME_NS 200
`define NS_TO_CYCLES_UP(ns) (((ns) * `SYS_CLK_MHZ + 999) / 1000)
`define STARTUP_CYCLES `NS_TO_CYCLES_UP(`STARTUP_TIME_NS)
`define SAR_SETTLE_CYCLES `NS_TO_CYCLES_UP(`SAR_SETTLE_NS)
`define ALIGN_CYCLES `NS_TO_CYCLES_UP(`ALIGN_TIME_NS)

`endif

/* hw/sar_calibrator.v */
// Successive approximation calibration engine driving a trial code
`timescale 1ns/1ns
`include "gen_ctrl_map.vh"
module sar_calibrator #(
	parameter WIDTH = 6
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// Control
	input wire start,
	input wire compare_high,
	output reg busy,
	output reg done,
	// Codes
	output reg [WIDTH-1:0] trial_code,
	output reg [WIDTH-1:0] result_code
);
	localparam integer SETTLE_INT = `SAR_SETTLE_CYCLES;
	localparam integer TOP_INT = WIDTH - 1;
	localparam [7:0] SETTLE_CYCLES = SETTLE_INT[7:0];
	localparam [4:0] TOP_BIT = TOP_INT[4:0];

	reg [7:0] settle_cnt;
	reg [4:0] bit_idx;
	reg [WIDTH-1:0] next_trial;
	integer i;

	// Keep current bit unless comparator says too high; set next bit
	always @* begin
		next_trial = trial_code;
		for (i = 0; i < WIDTH; i = i + 1) begin
			if (i == bit_idx) begin
				next_trial[i] = ~compare_high;
			end
			if (i + 1 == bit_idx) begin
				next_trial[i] = 1'b1;
			end
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			busy <= 1'b0;
			done <= 1'b0;
			settle_cnt <= 8'h00;
			bit_idx <= 5'h00;
			trial_code <= {WIDTH{1'b0}};
			result_code <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy <= 1'b1;
					bit_idx <= TOP_BIT;
					settle_cnt <= 8'h00;
					trial_code <= {1'b1, {(WIDTH-1){1'b0}}};
				end
			end else if (settle_cnt != SETTLE_CYCLES - 8'h01) begin
				settle_cnt <= settle_cnt + 8'h01;
			end else begin
				settle_cnt <= 8'h00;
				trial_code <= next_trial;
				if (bit_idx == 5'h00) begin
					busy <= 1'b0;
					done <= 1'b1;
					result_code <= next_trial;
				end else begin
					bit_idx <= bit_idx - 5'h01;
				end
			end
		end
	end
endmodule

/* hw/general_control_status_regs.v */
// General control and status register bank behind a 3-wire SPI port
`timescale 1ns/1ns
`include "gen_ctrl_map.vh"
module general_control_status_regs (
	// Clock, reset, enable
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// 3-wire SPI
	input wire spi_cs_b,
	input wire spi_sclk,
	input wire spi_sdat_in,
	output reg spi_sdat_out,
	output reg spi_sdat_oe,
	// Reference input for alignment
	input wire sysref_in,
	// Analog comparators
	input wire dcb_compare_high,
	input wire bias_compare_high,
	// Engine outputs
	output reg div_init_pulse,
	output reg align_phase_reset,
	output wire [14:0] dcb_trial_code,
	output wire [5:0] bias_trial_code
);
	localparam integer STARTUP_INT = `STARTUP_CYCLES;
	localparam integer ALIGN_INT = `ALIGN_CYCLES;
	localparam [9:0] STARTUP_CYCLES = STARTUP_INT[9:0];
	localparam [9:0] ALIGN_CYCLES = ALIGN_INT[9:0];
	localparam [1:0] ALIGN_IDLE = 2'h0;
	localparam [1:0] ALIGN_WAIT_EDGE = 2'h1;
	localparam [1:0] ALIGN_RUN = 2'h2;

	// Sampled pins
	reg sclk_d;
	reg sysref_d;
	wire sclk_rise = spi_sclk & ~sclk_d;
	wire sclk_fall = ~spi_sclk & sclk_d;
	wire sysref_rise = sysref_in & ~sysref_d;

	// SPI shifter state
	reg [4:0] bit_cnt;
	reg [14:0] shift_in;
	reg [7:0] rd_shift;
	reg reading;
	reg wr_stb;
	reg [6:0] wr_addr;
	reg [7:0] wr_data;

	// Control and status state
	reg readback_edge_select;
	reg multi_align_start;
	reg div_init_trigger;
	reg delay_cal_trigger;
	reg bias_cal_trigger;
	reg startup_done_flag;
	reg [9:0] startup_cnt;
	reg [1:0] align_state;
	reg [9:0] align_cnt;
	reg [1:0] next_align_state;

	// Engine handshakes
	wire dcb_busy;
	wire dcb_done;
	wire bias_busy;
	wire bias_done;
	wire [14:0] calib_code;
	wire [5:0] bias_level_code;
	wire dcb_start = delay_cal_trigger & ~dcb_busy & ~dcb_done;
	wire bias_start = bias_cal_trigger & ~bias_busy & ~bias_done;
	wire align_pending_flag = (align_state != ALIGN_IDLE);

	// Write decode helpers
	function wr_hit;
		input [6:0] addr;
		begin
			wr_hit = wr_stb && (wr_addr == addr);
		end
	endfunction

	function trig_hit;
		input [6:0] addr;
		begin
			trig_hit = wr_stb && (wr_addr == addr) && wr_data[`TRIGGER_BIT];
		end
	endfunction

	// Register read mux; write-only and reserved bits read zero
	function [7:0] reg_read;
		input [6:0] addr;
		begin
			reg_read = 8'h00;
			case (addr)
				`ADDR_CALIB_CODE_HIGH: begin
					reg_read[6:0] = calib_code[`CALIB_HIGH_MSB:`CALIB_HIGH_LSB];
				end
				`ADDR_CALIB_CODE_LOW: begin
					reg_read = calib_code[`CALIB_LOW_MSB:0];
				end
				`ADDR_DEVICE_STATUS: begin
					reg_read[`STATUS_ALIGN_BIT] = align_pending_flag;
					reg_read[`STATUS_READY_BIT] = startup_done_flag;
				end
				`ADDR_BIAS_LEVEL_READOUT: begin
					reg_read[5:0] = bias_level_code;
				end
				`ADDR_ALIGN_AND_SPI_CONTROL: begin
					reg_read[`TRIGGER_BIT] = multi_align_start;
					reg_read[`EDGE_SELECT_BIT] = readback_edge_select;
				end
				default: begin
					reg_read = 8'h00;
				end
			endcase
		end
	endfunction

	// Pin sampling
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			sclk_d <= 1'b0;
			sysref_d <= 1'b0;
		end else if (clk_en) begin
			sclk_d <= spi_sclk;
			sysref_d <= sysref_in;
		end
	end

	// SPI frame: rising edges shift in; read data leaves on the selected edge
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			bit_cnt <= 5'h00;
			shift_in <= 15'h0000;
			rd_shift <= 8'h00;
			reading <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 7'h00;
			wr_data <= 8'h00;
			spi_sdat_out <= 1'b0;
			spi_sdat_oe <= 1'b0;
		end else if (clk_en) begin
			wr_stb <= 1'b0;
			if (spi_cs_b) begin
				bit_cnt <= 5'h00;
				reading <= 1'b0;
				spi_sdat_oe <= 1'b0;
				spi_sdat_out <= 1'b0;
			end else begin
				if (sclk_rise && bit_cnt != `FRAME_BITS) begin
					shift_in <= {shift_in[13:0], spi_sdat_in};
					bit_cnt <= bit_cnt + 5'h01;
					if (bit_cnt == `HEADER_LAST_BIT && shift_in[6]) begin
						reading <= 1'b1;
						spi_sdat_oe <= 1'b1;
						rd_shift <= reg_read({shift_in[5:0], spi_sdat_in});
					end
					if (bit_cnt == `FRAME_LAST_BIT && !reading) begin
						wr_stb <= 1'b1;
						wr_addr <= shift_in[13:7];
						wr_data <= {shift_in[6:0], spi_sdat_in};
					end
				end
				// First selected edge after the header carries bit 7
				if (reading && bit_cnt > `HEADER_LAST_BIT &&
					(readback_edge_select ? sclk_rise : sclk_fall)) begin
					spi_sdat_out <= rd_shift[7];
					rd_shift <= {rd_shift[6:0], 1'b0};
				end
			end
		end
	end

	// Startup routine timer
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			startup_cnt <= 10'h000;
			startup_done_flag <= 1'b0;
		end else if (clk_en && !startup_done_flag) begin
			if (startup_cnt == STARTUP_CYCLES - 10'h001) begin
				startup_done_flag <= 1'b1;
			end else begin
				startup_cnt <= startup_cnt + 10'h001;
			end
		end
	end

	// Trigger bits, control register and divider init pulse
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			readback_edge_select <= `EDGE_SELECT_RESET;
			div_init_trigger <= 1'b0;
			div_init_pulse <= 1'b0;
			delay_cal_trigger <= 1'b0;
			bias_cal_trigger <= 1'b0;
		end else if (clk_en) begin
			if (wr_hit(`ADDR_ALIGN_AND_SPI_CONTROL)) begin
				readback_edge_select <= wr_data[`EDGE_SELECT_BIT];
			end
			div_init_pulse <= div_init_trigger;
			if (trig_hit(`ADDR_DIVIDER_INIT_CONTROL)) begin
				div_init_trigger <= 1'b1;
			end else begin
				div_init_trigger <= 1'b0;
			end
			if (trig_hit(`ADDR_DELAY_CAL_CONTROL)) begin
				delay_cal_trigger <= 1'b1;
			end else if (dcb_done) begin
				delay_cal_trigger <= 1'b0;
			end
			if (trig_hit(`ADDR_BIAS_CAL_CONTROL)) begin
				bias_cal_trigger <= 1'b1;
			end else if (bias_done) begin
				bias_cal_trigger <= 1'b0;
			end
		end
	end

	// Alignment sequencer
	always @* begin
		next_align_state = align_state;
		case (align_state)
			ALIGN_IDLE: begin
				if (multi_align_start) begin
					next_align_state = ALIGN_WAIT_EDGE;
				end
			end
			ALIGN_WAIT_EDGE: begin
				if (sysref_rise) begin
					next_align_state = ALIGN_RUN;
				end
			end
			ALIGN_RUN: begin
				if (align_cnt == ALIGN_CYCLES - 10'h001) begin
					next_align_state = ALIGN_IDLE;
				end
			end
			default: begin
				next_align_state = ALIGN_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			align_state <= ALIGN_IDLE;
			align_cnt <= 10'h000;
			multi_align_start <= `ALIGN_START_RESET;
			align_phase_reset <= 1'b0;
		end else if (clk_en) begin
			align_state <= next_align_state;
			align_phase_reset <= (next_align_state == ALIGN_RUN);
			if (align_state == ALIGN_RUN) begin
				align_cnt <= align_cnt + 10'h001;
			end else begin
				align_cnt <= 10'h000;
			end
			if (trig_hit(`ADDR_ALIGN_AND_SPI_CONTROL)) begin
				multi_align_start <= 1'b1;
			end else if (align_state == ALIGN_IDLE) begin
				multi_align_start <= 1'b0;
			end
		end
	end

	// Delay calibration block engine
	sar_calibrator #(
		.WIDTH(`CALIB_CODE_WIDTH)
	) u_delay_cal_trigger (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.start(dcb_start),
		.compare_high(dcb_compare_high),
		.busy(dcb_busy),
		.done(dcb_done),
		.trial_code(dcb_trial_code),
		.result_code(calib_code)
	);

	// Precision bias engine
	sar_calibrator #(
		.WIDTH(`BIAS_CODE_WIDTH)
	) u_bias_cal (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.start(bias_start),
		.compare_high(bias_compare_high),
		.busy(bias_busy),
		.done(bias_done),
		.trial_code(bias_trial_code),
		.result_code(bias_level_code)
	);
endmodule

/* verif/general_control_status_regs_sva.sv */
// Port assertions for the general control bank
`timescale 1ns/1ns
`include "gen_ctrl_map.vh"
module gcs_sva (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	// SPI
	input wire spi_cs_b,
	input wire spi_sclk,
	input wire spi_sdat_out,
	input wire spi_sdat_oe,
	// Engines
	input wire sysref_in,
	input wire div_init_pulse,
	input wire align_phase_reset
);
	reg [7:0] run_cnt;
	always @(posedge sys_clk) begin
		if (!rst_b || !align_phase_reset) begin
			run_cnt <= 8'h00;
		end else begin
			run_cnt <= run_cnt + 8'h01;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_init_single: assert property (
		div_init_pulse |=> (!div_init_pulse) [*8]) else $error("init pulse repeated");
	a_oe_release: assert property (
		spi_cs_b |=> !spi_sdat_oe) else $error("drive outside frame");
	a_oe_holds: assert property (
		spi_sdat_oe && !spi_cs_b |=> spi_sdat_oe) else $error("drive dropped");
	a_oe_rise_edge: assert property (
		$rose(spi_sdat_oe) |-> $past(spi_sclk) && !spi_cs_b) else $error("drive start");
	a_out_holds: assert property (
		(spi_sdat_oe && $stable(spi_sclk)) [*6] |-> $stable(spi_sdat_out))
		else $error("data moved without edge");
	a_run_length: assert property (
		$fell(align_phase_reset) |-> run_cnt == `ALIGN_CYCLES) else $error("run length");
	a_run_after_ref: assert property (
		$rose(align_phase_reset) |-> $past(sysref_in) || $past(sysref_in, 3))
		else $error("run without reference");
	a_run_once: assert property (
		$fell(align_phase_reset) |=> (!align_phase_reset) [*8]) else $error("run again");
endmodule
bind general_control_status_regs gcs_sva gcs_sva_i (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.spi_cs_b(spi_cs_b),
	.spi_sclk(spi_sclk),
	.spi_sdat_out(spi_sdat_out),
	.spi_sdat_oe(spi_sdat_oe),
	.sysref_in(sysref_in),
	.div_init_pulse(div_init_pulse),
	.align_phase_reset(align_phase_reset)
);

/* verif/spi_host_model.sv */
// SPI host model sending 16-bit frames on the 3-wire port
`timescale 1ns/1ns
module spi_host_model (
	// Clock
	input wire sys_clk,
	// 3-wire port
	input wire sdat,
	output reg cs_b,
	output reg sclk,
	output reg drv_en,
	output reg drv_val
);
	integer ph = 4;
	reg esel = 1'b0;
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		drv_en = 1'b1;
		drv_val = 1'b0;
	end
	task xfer(input rd, input [6:0] a, input [7:0] d, output [7:0] q);
		reg [15:0] f;
		integer i;
	begin
		f = {rd, a, d};
		q = 8'h00;
		@(posedge sys_clk);
		cs_b <= 1'b0;
		for (i = 15; i >= 0; i = i - 1) begin
			sclk <= 1'b0;
			drv_en <= !(rd && i < 8);
			drv_val <= f[i];
			repeat (ph) @(posedge sys_clk);
			if (rd && i < 8 && !esel) q[i] = sdat;
			sclk <= 1'b1;
			repeat (ph) @(posedge sys_clk);
			if (rd && i < 8 && esel) q[i] = sdat;
		end
		sclk <= 1'b0;
		repeat (ph) @(posedge sys_clk);
		cs_b <= 1'b1;
		drv_en <= 1'b1;
		if (!rd && a == 7'h73) esel = d[0];
		repeat (2) @(posedge sys_clk);
	end
	endtask
endmodule

/* verif/test_general_control_status_regs.sv */
// Self-checking bench for the general control bank
`timescale 1ns/1ns
`include "gen_ctrl_map.vh"
module test_general_control_status_regs;
	reg sys_clk = 1'b0;
	reg rst_b = 1'b0;
	reg sysref_in = 1'b0;
	reg dcb_cmp = 1'b0;
	reg bias_cmp = 1'b0;
	reg noise = 1'b0;
	reg [31:0] seed = 32'h4935;
	reg [14:0] dcb_t = 15'h0000;
	reg [5:0] bias_t = 6'h00;
	integer bad_count = 0;
	integer n_compared = 0;
	integer npulse = 0;
	integer nrun = 0;
	integer k;
	wire phase_rst;
	wire cs_b, sclk, drv_en, drv_val, sdat_out, sdat_oe, sdat, div_init;
	wire [14:0] dcb_code;
	wire [5:0] bias_code;
	// Released line shows a toggling level
	assign sdat = sdat_oe ? sdat_out : (drv_en ? drv_val : noise);
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		noise <= ~noise;
		dcb_cmp <= dcb_code > dcb_t;
		bias_cmp <= bias_code > bias_t;
		if (div_init === 1'b1) npulse = npulse + 1;
		if (phase_rst === 1'b1) nrun = nrun + 1;
	end
	spi_host_model spi_host_model_i (
		.sys_clk(sys_clk),
		.sdat(sdat),
		.cs_b(cs_b),
		.sclk(sclk),
		.drv_en(drv_en),
		.drv_val(drv_val)
	);
	general_control_status_regs general_control_status_regs_i (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clk_en(1'b1),
		.spi_cs_b(cs_b),
		.spi_sclk(sclk),
		.spi_sdat_in(sdat),
		.spi_sdat_out(sdat_out),
		.spi_sdat_oe(sdat_oe),
		.sysref_in(sysref_in),
		.dcb_compare_high(dcb_cmp),
		.bias_compare_high(bias_cmp),
		.div_init_pulse(div_init),
		.align_phase_reset(phase_rst),
		.dcb_trial_code(dcb_code),
		.bias_trial_code(bias_code)
	);
	function [31:0] xs(input [31:0] s);
		reg [31:0] x;
	begin
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	end
	endfunction
	function [7:0] st(input ready, input pend);
		st = {2'b00, pend, 3'b000, ready, 1'b0};
	endfunction
	task check(input [6:0] a, input [7:0] e, input [7:0] g);
	begin
		n_compared = n_compared + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("Error reg %h expected %h seen %h", a, e, g);
		end
	end
	endtask
	task rd(input [6:0] a, input [7:0] e);
		reg [7:0] q;
	begin
		spi_host_model_i.xfer(1'b1, a, 8'h00, q);
		check(a, e, q);
	end
	endtask
	task wr(input [6:0] a, input [7:0] d);
		reg [7:0] q;
	begin
		spi_host_model_i.xfer(1'b0, a, d, q);
	end
	endtask
	task finish_test;
	begin
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	end
	endtask
	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count = bad_count + 1;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(7'h6E, st(1'b0, 1'b0));
		rd(7'h73, 8'h00);
		rd(7'h10, 8'h00);
		repeat (250) @(posedge sys_clk);
		rd(7'h6E, st(1'b1, 1'b0));
		wr(7'h70, 8'h80);
		wr(7'h70, 8'h7F);
		rd(7'h70, 8'h00);
		check(7'h70, 8'h01, npulse[7:0]);
		for (k = 0; k < 4; k = k + 1) begin
			seed = xs(seed);
			dcb_t <= seed[14:0];
			bias_t <= seed[20:15];
			spi_host_model_i.ph = k[1] ? 8 : 3;
			wr(7'h73, {7'h00, k[0]});
			wr(7'h72, 8'h80);
			wr(7'h71, 8'h80);
			repeat (200) @(posedge sys_clk);
			wr(7'h6F, 8'hFF);
			rd(7'h6F, {2'b00, bias_t});
			rd(7'h6C, {1'b0, dcb_t[14:8]});
			rd(7'h6D, dcb_t[7:0]);
			rd(7'h73, {7'h00, k[0]});
			// An engine that restarted would show a fresh trial code
			check(7'h72, {2'b00, bias_t}, {2'b00, bias_code});
			check(7'h71, dcb_t[7:0], dcb_code[7:0]);
		end
		wr(7'h73, 8'h81);
		seed = xs(seed);
		repeat (seed[3:0]) @(posedge sys_clk);
		rd(7'h6E, st(1'b1, 1'b1));
		sysref_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		sysref_in <= 1'b0;
		repeat (80) @(posedge sys_clk);
		rd(7'h6E, st(1'b1, 1'b0));
		rd(7'h73, 8'h01);
		check(7'h6E, `ALIGN_CYCLES, nrun[7:0]);
		finish_test;
	end
endmodule
